// >>> src/clock_speed_and_pll_config.sv
/*
 * Clock speed and PLL configuration registers with an AXI4-Lite slave,
 * clock tick generation for CPU, peripherals and machine cycles.
 * Assumes REF_CLK_IN is the oscillator clock, RESET_IN is the chip reset
 * and the analog PLL sits outside, reporting lock on PLL_LOCK_IN.
 */
// Behaviour
// - Bit 7 picks two-wire clock source
// - Bit 6 picks watchdog clock source
// - Bit 4 picks UART clock source
// - Bit 2 picks timer one source
// - Bit 1 picks timer zero source
// - Bit 0 sets six or twelve periods
// - Reset clears mode bits except bit zero
// - Bit zero loads from boot configuration
// - Mode bits 5 and 3 are unused
// - Hold reset bit resets to one
// - Enable bit switches PLL on, off
// - Lock bit is hardware only, read-only
// - R divider splits across two registers
// - N divider seven bits, top reads zero
// - PLL control bits 5,4,2 read zero
// - Dividers feed the PLL comparator
`default_nettype none

module clock_speed_and_pll_config
#(
   parameter int ADDR_W        = 12,
   parameter bit FLASH_VARIANT = 1'b1
)
(
   input  wire logic                  REF_CLK_IN,
   input  wire logic                  RESET_IN,
   input  wire logic [ADDR_W-1:0]     AWADDR_IN,
   input  wire logic                  AWVALID_IN,
   output var  logic                  AWREADY_OUT,
   input  wire logic [31:0]           WDATA_IN,
   input  wire logic [3:0]            WSTRB_IN,
   input  wire logic                  WVALID_IN,
   output var  logic                  WREADY_OUT,
   output var  logic [1:0]            BRESP_OUT,
   output var  logic                  BVALID_OUT,
   input  wire logic                  BREADY_IN,
   input  wire logic [ADDR_W-1:0]     ARADDR_IN,
   input  wire logic                  ARVALID_IN,
   output var  logic                  ARREADY_OUT,
   output var  logic [31:0]           RDATA_OUT,
   output var  logic [1:0]            RRESP_OUT,
   output var  logic                  RVALID_OUT,
   input  wire logic                  RREADY_IN,
   input  wire logic                  DOUBLE_SPEED_BOOT_IN,
   input  wire logic                  PLL_LOCK_IN,
   output var  logic                  DOUBLE_SPEED_OUT,
   output var  clk_ctrl_pkg::clk_tick_s TICK_OUT,
   output var  clk_ctrl_pkg::pll_cfg_s  PLL_CFG_OUT
);

   import clk_ctrl_pkg::*;

   ctrl_state_s st_r;
   ctrl_state_s st_nxt;
   logic        lock_level;
   logic        per_tick;
   logic [3:0]  mc_limit;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic reg_sel_e decode_f(input logic [ADDR_W-1:0] addr);
      reg_sel_e sel;
      logic [ADDR_W-3:0] idx;
      idx = addr[ADDR_W-1:2];
      if (idx == (ADDR_W-2)'(CLK_MODE_IDX))
      begin
         sel = SEL_CLK_MODE;
      end
      else if (idx == (ADDR_W-2)'(PLL_CTRL_IDX))
      begin
         sel = SEL_PLL_CTRL;
      end
      else if (idx == (ADDR_W-2)'(N_DIV_IDX))
      begin
         sel = SEL_N_DIV;
      end
      else if (idx == (ADDR_W-2)'(R_DIV_IDX))
      begin
         sel = SEL_R_DIV;
      end
      else
      begin
         sel = SEL_NONE;
      end
      return sel;
   endfunction

   // ---------------------------------------------------------------
   // Lock synchroniser
   // ---------------------------------------------------------------
   // lock level synchronised
   lock_sync u_lock_sync
   (
      .REF_CLK_IN    (REF_CLK_IN),
      .RESET_IN      (RESET_IN),
      .LOCK_ASYNC_IN (PLL_LOCK_IN),
      .LOCK_SYNC_OUT (lock_level)
   );

   // ---------------------------------------------------------------
   // Handshake outputs
   // ---------------------------------------------------------------
   assign AWREADY_OUT = !st_r.aw_got && !st_r.bvalid;
   assign WREADY_OUT  = !st_r.w_got && !st_r.bvalid;
   assign ARREADY_OUT = !st_r.rvalid;
   assign BVALID_OUT  = st_r.bvalid;
   assign BRESP_OUT   = st_r.bresp;
   assign RVALID_OUT  = st_r.rvalid;
   assign RRESP_OUT   = st_r.rresp;
   assign RDATA_OUT   = {24'h000000, st_r.rdata};

   // ---------------------------------------------------------------
   // Speed mode derived terms
   // ---------------------------------------------------------------
   // peripheral rate follows mode
   assign per_tick = st_r.double_speed | st_r.half_phase;
   assign mc_limit = st_r.double_speed ? DOUBLE_PERIODS : STD_PERIODS;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;

      // Write address and data capture
      if (AWVALID_IN && AWREADY_OUT)
      begin
         st_nxt.aw_got = 1'b1;
         st_nxt.aw_sel = decode_f(AWADDR_IN);
      end
      if (WVALID_IN && WREADY_OUT)
      begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = WDATA_IN[7:0];
         st_nxt.w_en   = WSTRB_IN[0];
      end

      // Register write once both halves are held
      if (st_r.aw_got && st_r.w_got)
      begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = RESP_OKAY;
         case (st_r.aw_sel)
            SEL_CLK_MODE:
            begin
               if (st_r.w_en)
               begin
                  st_nxt.periph_src[PERIPH_TWO_WIRE] = st_r.w_data[TWO_WIRE_BIT];
                  st_nxt.periph_src[PERIPH_WATCHDOG] = st_r.w_data[WATCHDOG_BIT];
                  st_nxt.periph_src[PERIPH_UART] = st_r.w_data[UART_BIT];
                  st_nxt.periph_src[PERIPH_TIMER_ONE] = st_r.w_data[TIMER_ONE_BIT];
                  st_nxt.periph_src[PERIPH_TIMER_ZERO] = st_r.w_data[TIMER_ZERO_BIT];
                  st_nxt.double_speed = st_r.w_data[DOUBLE_BIT];
               end
            end
            SEL_PLL_CTRL:
            begin
               if (st_r.w_en)
               begin
                  st_nxt.r_low = st_r.w_data[R_LOW_MSB:R_LOW_LSB];
                  st_nxt.hold_reset = st_r.w_data[HOLD_RESET_BIT];
                  st_nxt.enable = st_r.w_data[ENABLE_BIT];
               end
            end
            SEL_N_DIV:
            begin
               if (st_r.w_en)
               begin
                  st_nxt.n_div = st_r.w_data[6:0];
               end
            end
            SEL_R_DIV:
            begin
               if (st_r.w_en)
               begin
                  st_nxt.r_high = st_r.w_data;
               end
            end
            default:
            begin
               st_nxt.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Write response retire
      if (st_r.bvalid && BREADY_IN)
      begin
         st_nxt.bvalid = 1'b0;
      end

      // Read address capture and data
      if (ARVALID_IN && ARREADY_OUT)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = RESP_OKAY;
         case (decode_f(ARADDR_IN))
            SEL_CLK_MODE:
            begin
               st_nxt.rdata = {st_r.periph_src[PERIPH_TWO_WIRE],
                               st_r.periph_src[PERIPH_WATCHDOG], 1'b0,
                               st_r.periph_src[PERIPH_UART], 1'b0,
                               st_r.periph_src[PERIPH_TIMER_ONE],
                               st_r.periph_src[PERIPH_TIMER_ZERO],
                               st_r.double_speed};
            end
            SEL_PLL_CTRL:
            begin
               st_nxt.rdata = {st_r.r_low, 2'b00, st_r.hold_reset, 1'b0,
                               st_r.enable, lock_level};
            end
            SEL_N_DIV:
            begin
               st_nxt.rdata = {1'b0, st_r.n_div};
            end
            SEL_R_DIV:
            begin
               st_nxt.rdata = st_r.r_high;
            end
            default:
            begin
               st_nxt.rdata = 8'h00;
               st_nxt.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Read response retire
      if (st_r.rvalid && RREADY_IN)
      begin
         st_nxt.rvalid = 1'b0;
      end

      // Oscillator divided by two phase
      st_nxt.half_phase = !st_r.half_phase;

      if (st_r.mc_count >= mc_limit - 4'h1)
      begin
         st_nxt.mc_count = 4'h0;
      end
      else
      begin
         st_nxt.mc_count = st_r.mc_count + 4'h1;
      end
      st_nxt.ticks.machine = (st_r.mc_count >= mc_limit - 4'h1);

      st_nxt.ticks.cpu = per_tick;
      st_nxt.ticks.per = per_tick;

      for (int i = 0; i < 5; i++)
      begin
         st_nxt.ticks.periph[i] = st_r.periph_src[i] ? st_r.half_phase : per_tick;
      end

      if (RESET_IN)
      begin
         st_nxt              = '0;
         st_nxt.aw_sel       = SEL_NONE;
         st_nxt.bresp        = RESP_OKAY;
         st_nxt.rresp        = RESP_OKAY;
         st_nxt.periph_src   = {CLK_MODE_RESET[TWO_WIRE_BIT],
                                CLK_MODE_RESET[WATCHDOG_BIT],
                                CLK_MODE_RESET[UART_BIT],
                                CLK_MODE_RESET[TIMER_ONE_BIT],
                                CLK_MODE_RESET[TIMER_ZERO_BIT]};
         st_nxt.double_speed = FLASH_VARIANT && DOUBLE_SPEED_BOOT_IN;
         st_nxt.r_low        = PLL_CTRL_RESET[R_LOW_MSB:R_LOW_LSB];
         st_nxt.hold_reset   = PLL_CTRL_RESET[HOLD_RESET_BIT];
         st_nxt.enable       = PLL_CTRL_RESET[ENABLE_BIT];
         st_nxt.n_div        = N_DIV_RESET[6:0];
         st_nxt.r_high       = R_DIV_RESET;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN)
   begin
      st_r <= st_nxt;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign DOUBLE_SPEED_OUT       = st_r.double_speed;
   assign TICK_OUT               = st_r.ticks;
   assign PLL_CFG_OUT            = {st_r.hold_reset, st_r.enable, st_r.n_div,
                                    st_r.r_high, st_r.r_low};

endmodule // clock_speed_and_pll_config

`default_nettype wire

// >>> src/clk_ctrl_pkg.sv
/*
 * Constants, register map and state types for the clock speed and PLL
 * configuration block.
 * Assumes a 32-bit AXI4-Lite register bus whose byte address is four
 * times the register index.
 */
`default_nettype none

package clk_ctrl_pkg;

   // ---------------------------------------------------------------
   // Register indices and byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] CLK_MODE_IDX  = 8'h8F;
   localparam logic [7:0] PLL_CTRL_IDX  = 8'hE9;
   localparam logic [7:0] N_DIV_IDX     = 8'hEE;
   localparam logic [7:0] R_DIV_IDX     = 8'hEF;
   localparam logic [9:0] CLK_MODE_ADDR = {CLK_MODE_IDX, 2'b00};
   localparam logic [9:0] PLL_CTRL_ADDR = {PLL_CTRL_IDX, 2'b00};
   localparam logic [9:0] N_DIV_ADDR    = {N_DIV_IDX, 2'b00};
   localparam logic [9:0] R_DIV_ADDR    = {R_DIV_IDX, 2'b00};

   // ---------------------------------------------------------------
   // Clock mode control fields
   // ---------------------------------------------------------------
   localparam int TWO_WIRE_BIT   = 7;
   localparam int WATCHDOG_BIT   = 6;
   localparam int UART_BIT       = 4;
   localparam int TIMER_ONE_BIT  = 2;
   localparam int TIMER_ZERO_BIT = 1;
   localparam int DOUBLE_BIT     = 0;
   localparam logic [7:0] CLK_MODE_RESET = 8'h00;

   // ---------------------------------------------------------------
   // PLL control and divider fields
   // ---------------------------------------------------------------
   localparam int R_LOW_MSB       = 7;
   localparam int R_LOW_LSB       = 6;
   localparam int HOLD_RESET_BIT  = 3;
   localparam int ENABLE_BIT      = 1;
   localparam int LOCK_BIT        = 0;
   localparam logic [7:0] PLL_CTRL_RESET = 8'h08;
   localparam logic [7:0] N_DIV_RESET    = 8'h00;
   localparam logic [7:0] R_DIV_RESET    = 8'h00;

   // ---------------------------------------------------------------
   // Machine cycle lengths in oscillator periods
   // ---------------------------------------------------------------
   localparam logic [3:0] STD_PERIODS    = 4'hC;
   localparam logic [3:0] DOUBLE_PERIODS = 4'h6;

   // ---------------------------------------------------------------
   // Peripheral tick positions
   // ---------------------------------------------------------------
   localparam int PERIPH_TWO_WIRE   = 4;
   localparam int PERIPH_WATCHDOG   = 3;
   localparam int PERIPH_UART       = 2;
   localparam int PERIPH_TIMER_ONE  = 1;
   localparam int PERIPH_TIMER_ZERO = 0;

   // ---------------------------------------------------------------
   // Bus responses
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0]
   {
      SEL_NONE     = 3'b000,
      SEL_CLK_MODE = 3'b001,
      SEL_PLL_CTRL = 3'b010,
      SEL_N_DIV    = 3'b011,
      SEL_R_DIV    = 3'b100
   } reg_sel_e;

   typedef struct packed
   {
      logic       cpu;
      logic       per;
      logic       machine;
      logic [4:0] periph;
   } clk_tick_s;

   typedef struct packed
   {
      logic       hold_reset;
      logic       enable;
      logic [6:0] n_div;
      logic [9:0] r_div;
   } pll_cfg_s;

   typedef struct packed
   {
      reg_sel_e   aw_sel;
      logic       aw_got;
      logic [7:0] w_data;
      logic       w_en;
      logic       w_got;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [4:0] periph_src;
      logic       double_speed;
      logic [1:0] r_low;
      logic       hold_reset;
      logic       enable;
      logic [6:0] n_div;
      logic [7:0] r_high;
      logic       half_phase;
      logic [3:0] mc_count;
      clk_tick_s  ticks;
   } ctrl_state_s;

endpackage

`default_nettype wire

// >>> src/lock_sync.sv
/*
 * Two-stage synchroniser for the PLL lock level.
 * Assumes the lock level is asynchronous to the register clock.
 */
`default_nettype none

module lock_sync
(
   input  wire logic REF_CLK_IN,
   input  wire logic RESET_IN,
   input  wire logic LOCK_ASYNC_IN,
   output var  logic LOCK_SYNC_OUT
);

   logic meta_r;
   logic sync_r;

   // ---------------------------------------------------------------
   // Synchroniser stages
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end
      else
      begin
         meta_r <= LOCK_ASYNC_IN;
         sync_r <= meta_r;
      end
   end

   assign LOCK_SYNC_OUT = sync_r;

endmodule // lock_sync

`default_nettype wire

// >>> testbench/clock_speed_and_pll_config_properties.sv
/*
 * Port checker for the clock speed and PLL configuration block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`default_nettype none

module clock_speed_and_pll_config_properties
(
   input wire logic                    REF_CLK_IN,
   input wire logic                    RESET_IN,
   input wire logic                    ARVALID_IN,
   input wire logic                    ARREADY_OUT,
   input wire logic                    RVALID_OUT,
   input wire logic                    RREADY_IN,
   input wire logic [31:0]             RDATA_OUT,
   input wire logic                    BVALID_OUT,
   input wire logic                    BREADY_IN,
   input wire logic [1:0]              BRESP_OUT,
   input wire logic                    DOUBLE_SPEED_OUT,
   input wire clk_ctrl_pkg::clk_tick_s TICK_OUT,
   input wire clk_ctrl_pkg::pll_cfg_s  PLL_CFG_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   import clk_ctrl_pkg::*;

   logic [3:0] gap_r;
   logic       clean_r;
   logic       dbl_q_r;
   logic [1:0] run_r;

   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);

   // -------------------------------------------------------------
   // Machine cycle gap tracking
   // -------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN)
   begin
      dbl_q_r <= DOUBLE_SPEED_OUT;
      if (RESET_IN)
      begin
         gap_r   <= 4'h0;
         clean_r <= 1'b0;
         run_r   <= 2'h0;
      end
      else
      begin
         gap_r   <= TICK_OUT.machine ? 4'h0 : gap_r + 4'h1;
         clean_r <= (TICK_OUT.machine | clean_r) & (DOUBLE_SPEED_OUT == dbl_q_r);
         run_r   <= (run_r == 2'h3) ? run_r : run_r + 2'h1;
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   AST_MACH_LEN: assert property (TICK_OUT.machine && clean_r && DOUBLE_SPEED_OUT == dbl_q_r
      |-> gap_r == (DOUBLE_SPEED_OUT ? DOUBLE_PERIODS - 4'h1 : STD_PERIODS - 4'h1))
      else $error("machine tick spacing wrong");
   AST_MACH_GAP: assert property (clean_r && DOUBLE_SPEED_OUT == dbl_q_r
      |-> gap_r <= (DOUBLE_SPEED_OUT ? DOUBLE_PERIODS - 4'h1 : STD_PERIODS - 4'h1))
      else $error("machine tick missing");
   AST_STD_PER: assert property (run_r == 2'h3 && !DOUBLE_SPEED_OUT && !dbl_q_r
      && !$past(dbl_q_r) && $past(TICK_OUT.per) |-> !TICK_OUT.per)
      else $error("standard tick too fast");
   AST_DBL_PER: assert property (run_r == 2'h3 && DOUBLE_SPEED_OUT && dbl_q_r
      && $past(dbl_q_r) |-> TICK_OUT.per)
      else $error("double speed tick missing");
   AST_CPU_PER: assert property (TICK_OUT.cpu == TICK_OUT.per)
      else $error("cpu and peripheral ticks differ");
   AST_OSC_HALF: assert property (|(TICK_OUT.periph & $past(TICK_OUT.periph))
      |-> DOUBLE_SPEED_OUT || dbl_q_r || $past(dbl_q_r))
      else $error("peripheral tick too fast");
   AST_PLL_RESET: assert property ($fell(RESET_IN) |-> PLL_CFG_OUT == {1'b1, 18'h0})
      else $error("pll config reset value wrong");
   AST_B_HOLD: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
      else $error("write response dropped");
   AST_R_HOLD: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
      else $error("read data dropped");
   AST_RD_LAT: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT ##0 !ARREADY_OUT)
      else $error("read answer late");

   cover property (TICK_OUT.machine && DOUBLE_SPEED_OUT);
   cover property (TICK_OUT.periph != {5{TICK_OUT.per}});
   cover property (BVALID_OUT && BREADY_IN);

endmodule // clock_speed_and_pll_config_properties

bind clock_speed_and_pll_config clock_speed_and_pll_config_properties u_props
(
   .REF_CLK_IN, .RESET_IN, .ARVALID_IN, .ARREADY_OUT, .RVALID_OUT, .RREADY_IN, .RDATA_OUT,
   .BVALID_OUT, .BREADY_IN, .BRESP_OUT, .DOUBLE_SPEED_OUT, .TICK_OUT, .PLL_CFG_OUT
);

`default_nettype wire

// >>> testbench/tb_clock_speed_and_pll_config.sv
/*
 * Self-checking bench for the clock speed and PLL configuration block.
 * Assumes the package, design and checker are compiled before it.
 */
`default_nettype none

module tb_clock_speed_and_pll_config;
   timeunit 1ns;
   timeprecision 1ps;
   import clk_ctrl_pkg::*;

   localparam logic [11:0] a_cm = {2'b00, CLK_MODE_ADDR};
   localparam logic [11:0] a_pl = {2'b00, PLL_CTRL_ADDR};
   localparam logic [11:0] a_nd = {2'b00, N_DIV_ADDR};
   localparam logic [11:0] a_rd = {2'b00, R_DIV_ADDR};
   localparam int bp[5] = '{TIMER_ZERO_BIT, TIMER_ONE_BIT, UART_BIT, WATCHDOG_BIT, TWO_WIRE_BIT};

   logic        clk = 1'b0, rst = 1'b1, boot = 1'b1, lock = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0]  wstrb = '0;
   logic        awready, wready, bvalid, arready, rvalid, dbl;
   logic [1:0]  bresp, rresp;
   clk_tick_s   tick;
   pll_cfg_s    cfg;
   logic [33:0] expq[$];
   logic [33:0] e;
   logic [4:0]  pa, po;
   logic [3:0]  gp;
   logic [3:0]  pc;
   logic [7:0]  n, r;
   int          err_total = 0, n_tests = 0;
   integer      seed = 32'hBD375B44;

   always #2 clk = ~clk;

   clock_speed_and_pll_config u_dut
   (
      .REF_CLK_IN(clk), .RESET_IN(rst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
      .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
      .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
      .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
      .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
      .DOUBLE_SPEED_BOOT_IN(boot), .PLL_LOCK_IN(lock), .DOUBLE_SPEED_OUT(dbl),
      .TICK_OUT(tick), .PLL_CFG_OUT(cfg)
   );

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
      n_tests++;
      if (sn !== ex)
      begin
         $display("BAD %s exp %h got %h", nm, ex, sn);
         err_total++;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st,
                     input logic [1:0] er);
      logic       at, wt, bt;
      logic [1:0] rs;
      @(posedge clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= {24'($random(seed)), d};
      wstrb   <= st;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(negedge clk);
         at = awvalid & awready;
         wt = wvalid & wready;
         bt = bvalid;
         rs = bresp;
         @(posedge clk);
         if (at) awvalid <= 1'b0;
         if (wt) wvalid <= 1'b0;
      end
      while (bt !== 1'b1);
      bready <= 1'b0;
      chk("bresp", 32'(er), 32'(rs));
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic at, rt;
      expq.push_back({er, 24'h0, d});
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(negedge clk);
         at = arvalid & arready;
         rt = rvalid;
         @(posedge clk);
         if (at) arvalid <= 1'b0;
      end
      while (rt !== 1'b1);
      rready <= 1'b0;
   endtask

   task automatic meas();
      repeat (3) @(posedge clk);
      pa = 5'h1F;
      po = 5'h00;
      pc = 4'h0;
      gp = 4'h0;
      repeat (4)
      begin
         @(negedge clk);
         pa &= tick.periph;
         po |= tick.periph;
         pc += {3'b000, tick.per} + {3'b000, tick.cpu};
      end
      do @(negedge clk); while (tick.machine !== 1'b1);
      do
      begin
         @(negedge clk);
         gp++;
      end
      while (tick.machine !== 1'b1);
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Read monitor and watchdog
   // -------------------------------------------------------------
   always @(negedge clk)
      if (rvalid === 1'b1 && rready)
      begin
         e = expq.pop_front();
         chk("rdata", e[31:0], rdata);
         chk("rresp", 32'(e[33:32]), 32'(rresp));
      end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      complete_run();
   end

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(a_cm, 8'h01, RESP_OKAY);
      rd(a_pl, PLL_CTRL_RESET, RESP_OKAY);
      rd(a_nd, N_DIV_RESET, RESP_OKAY);
      rd(a_rd, R_DIV_RESET, RESP_OKAY);
      chk("cfg", 32'({1'b1, 18'h0}), 32'(cfg));
      chk("dbl", 32'h1, 32'(dbl));
      meas();
      chk("per", 32'h8, 32'(pc));
      chk("gap", 32'(DOUBLE_PERIODS), 32'(gp));
      $display("test reset and double speed done");
      for (int i = 0; i < 5; i++)
      begin
         wr(a_cm, 8'h01 | (8'h01 << bp[i]), 4'hF, RESP_OKAY);
         meas();
         chk("all", 32'(5'h1F & ~(5'h01 << i)), 32'(pa));
         chk("any", 32'h1F, 32'(po));
      end
      wr(a_cm, 8'hD7, 4'hF, RESP_OKAY);
      rd(a_cm, 8'hD7, RESP_OKAY);
      wr(a_cm, 8'h00, 4'hF, RESP_OKAY);
      meas();
      chk("per", 32'h4, 32'(pc));
      chk("gap", 32'(STD_PERIODS), 32'(gp));
      wr(a_cm, 8'h01, 4'hE, RESP_OKAY);
      rd(a_cm, 8'h00, RESP_OKAY);
      wr(12'h004, 8'hFF, 4'hF, RESP_SLVERR);
      rd(12'h004, 8'h00, RESP_SLVERR);
      rd({2'b01, CLK_MODE_ADDR}, 8'h00, RESP_SLVERR);
      $display("test clock mode and bus done");
      wr(a_pl, 8'hCB, 4'hF, RESP_OKAY);
      rd(a_pl, 8'hCA, RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         n = 8'($random(seed));
         r = 8'($random(seed));
         wr(a_nd, n, 4'hF, RESP_OKAY);
         wr(a_rd, r, 4'hF, RESP_OKAY);
         rd(a_nd, {1'b0, n[6:0]}, RESP_OKAY);
         rd(a_rd, r, RESP_OKAY);
         settle();
         chk("cfg", 32'({2'b11, n[6:0], r, 2'b11}), 32'(cfg));
      end
      wr(a_pl, 8'h02, 4'hF, RESP_OKAY);
      settle();
      chk("cfg_top", 32'h1, 32'(cfg[18:17]));
      wr(a_pl, 8'h00, 4'hF, RESP_OKAY);
      settle();
      chk("cfg_top", 32'h0, 32'(cfg[18:17]));
      @(posedge clk);
      lock <= 1'b1;
      settle();
      rd(a_pl, 8'h01, RESP_OKAY);
      lock <= 1'b0;
      settle();
      rd(a_pl, 8'h00, RESP_OKAY);
      $display("test pll control done");
      wr(a_cm, 8'hD6, 4'hF, RESP_OKAY);
      boot <= 1'b0;
      rst  <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(a_cm, 8'h00, RESP_OKAY);
      rd(a_pl, PLL_CTRL_RESET, RESP_OKAY);
      $display("test second reset done");
      complete_run();
   end

endmodule // tb_clock_speed_and_pll_config

`default_nettype wire
